// *** cvr_pkg.sv ***
/*
 Constants for the codec reset and output volume register bank: register
 indices, field positions, write masks, values after reset and bus states.
 Assumes a 32-bit classic Wishbone slave with 16-bit registers in the low
 half of each word, byte address equal to four times the register index.
*/
package cvr_pkg;

   // Register indices; the byte address is four times the index
   localparam logic [6:0] IDX_SOFT_RESET = 7'h00;
   localparam logic [6:0] IDX_MASTER = 7'h02;
   localparam logic [6:0] IDX_HEADPHONE = 7'h04;
   localparam logic [6:0] IDX_MONO = 7'h06;
   localparam logic [6:0] IDX_SERIAL_CFG = 7'h74;
   localparam logic [6:0] IDX_STICKY_PAGE = 7'h7c;

   // Values after reset
   localparam logic [15:0] RST_MASTER = 16'h8080;
   localparam logic [15:0] RST_HEADPHONE = 16'h8080;
   localparam logic [15:0] RST_MONO = 16'h8000;
   localparam logic [15:0] RST_SERIAL_CFG = 16'h0000;
   localparam logic [15:0] RST_STICKY_PAGE = 16'h0000;

   // Writable bits; everything else is reserved and reads as zero
   localparam logic [15:0] MASK_STEREO = 16'h9f9f;
   localparam logic [15:0] MASK_MONO = 16'h801f;
   localparam logic [15:0] MASK_SERIAL_CFG = 16'hff80;
   localparam logic [15:0] MASK_STICKY_PAGE = 16'hffff;

   // Volume register fields
   localparam int LEFT_MUTE_BIT = 15;
   localparam int LEFT_VOL_LSB = 8;
   localparam int RIGHT_MUTE_BIT = 7;
   localparam int RIGHT_VOL_LSB = 0;
   localparam int VOL_WIDTH = 5;

   // Capability word fields
   localparam int CAP_LSB = 0;
   localparam int CAP_WIDTH = 10;
   localparam int ENH_LSB = 10;
   localparam logic [4:0] ENHANCEMENT_CODE = 5'h00;

   // Serial configuration fields
   localparam int SIXTEEN_SLOT_SELECT_BIT = 15;
   localparam int LINK_MODE_LSB = 12;
   localparam int SPDIF_OVERRIDE_BIT = 11;
   localparam int SPDIF_SLOT_ALLOC_LSB = 9;
   localparam int SPDIF_ZERO_FILL_BIT = 8;
   localparam int SPDIF_LINK_BIT = 7;

   // Attenuation in half-decibel units: one volume step is 1.5 dB
   localparam int ATT_WIDTH = 7;
   localparam logic [ATT_WIDTH-1:0] STEP_HALF_DB = 7'h03;

   // Output channels: line L/R, surround L/R, center/LFE, headphone L/R, mono
   localparam int NUM_CHAN = 9;
   localparam int NUM_MASTER_CHAN = 6;
   localparam int CHAN_HP_LEFT = 6;
   localparam int CHAN_HP_RIGHT = 7;
   localparam int CHAN_MONO = 8;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } cvr_bus_state_type;

endpackage

// *** cvr_sync2.sv ***
/*
 Two-stage synchroniser for a level arriving from outside the clock domain.
 Assumes the level is slow compared with clk_i; only the second stage is read.
*/
`timescale 1ns/100ps
module cvr_sync2 (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Level in and out
   input wire logic async_i,
   output logic sync_o
);

   logic stage1;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage1 <= 1'b1;
         sync_o <= 1'b1;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end

endmodule

// *** cvr_chan_level.sv ***
/*
 Registered decode of one output channel's mute bit and 5-bit volume code
 into a mute level and an attenuation in half-decibel units.
 Assumes the inputs come from register flops on the same clock.
*/
`timescale 1ns/100ps
module cvr_chan_level
   import cvr_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register fields
   input wire logic mute_i,
   input wire logic [VOL_WIDTH-1:0] code_i,
   // Decoded level
   output logic mute_o,
   output logic [ATT_WIDTH-1:0] atten_o
);

   logic [ATT_WIDTH-1:0] next_atten;

   // Code zero is 0 dB, all ones is 46.5 dB down
   always_comb begin
      next_atten = ATT_WIDTH'(code_i) * STEP_HALF_DB; // RULE9
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mute_o <= 1'b1;
         atten_o <= '0;
      end else begin
         mute_o <= mute_i; // RULE9
         atten_o <= next_atten;
      end
   end

endmodule

// *** cvr_regs.sv ***
/*
 Codec reset and output volume register bank behind a classic Wishbone slave.
 Holds the soft reset / capability word, master, headphone and mono volume,
 a serial configuration word and a sticky page word, and drives the decoded
 mute and attenuation of each analog output.
 Assumes rst_i is the power-on reset on clk_i and hw_reset_n_i is the
 asynchronous external hardware reset pin.
*/
// Design decision made here: the Wishbone interface to the registers.
// Behaviour
// RULE1: any write to index 0x00 returns registers to defaults, with exceptions
// RULE2: soft reset leaves serial configuration link and S/PDIF bits unchanged
// RULE3: serial configuration clears only on the external hardware reset; the code also clears it on power-on reset rst_i
// RULE4: sticky page word survives soft and hardware resets; power-on clears it
// RULE5: reset register reads capability in 9:0, enhancement code in 14:10
// RULE6: capability bits are read-only, each flagging one feature
// RULE7: enhancement code is read-only and reads as zero
// RULE8: master volume drives line, surround and center/LFE outputs together
// RULE9: volume code steps 1.5 dB from 0 to -46.5 dB; mute overrides
// RULE10: headphone register holds independent left/right volume and mute
// RULE11: mono register has volume 4:0, mute 15, resets muted at 0 dB
// RULE12: per-output fine control belongs to DAC volume registers elsewhere
// RULE13: reserved volume bits ignore writes and read as zero
`timescale 1ns/100ps
module cvr_regs
   import cvr_pkg::*;
#(
   // Arbitrary neutral value; identifies feature set only
   parameter logic [CAP_WIDTH-1:0] CAPABILITY = 10'h010
)
(
   // Clock and power-on reset
   input wire logic clk_i,
   input wire logic rst_i,
   // External hardware reset pin
   input wire logic hw_reset_n_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [8:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Serial link configuration
   output logic [15:0] serial_config_o,
   // Decoded output levels
   output logic [NUM_CHAN-1:0] chan_mute_o,
   output logic [NUM_CHAN-1:0][ATT_WIDTH-1:0] chan_atten_o
);

   cvr_bus_state_type bus_state;
   cvr_bus_state_type next_bus_state;
   logic hw_reset_n_sync;
   logic hw_reset;
   logic [6:0] index;
   logic write_take;
   logic soft_reset;
   logic [15:0] lane_mask;
   logic [15:0] master_vol;
   logic [15:0] headphone_vol;
   logic [15:0] mono_vol;
   logic [15:0] sticky_page;
   logic [15:0] next_read;
   logic [15:0] capability_word;
   logic [NUM_CHAN-1:0] chan_mute_src;
   logic [NUM_CHAN-1:0][VOL_WIDTH-1:0] chan_code_src;

   // Pin reset passes two flops before use
   cvr_sync2 u_hw_reset_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(hw_reset_n_i),
      .sync_o(hw_reset_n_sync)
   );

   assign hw_reset = ~hw_reset_n_sync;
   assign index = wb_adr_i[8:2];
   assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // Write takes effect at the edge where ack is high
   assign write_take = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
   assign soft_reset = write_take && (index == IDX_SOFT_RESET); // RULE1

   // Capability and enhancement code are constants, never stored
   assign capability_word = {1'b0, ENHANCEMENT_CODE, CAPABILITY}; // RULE5 RULE6 RULE7

   // Bus handshake: answer one cycle after the request, then drop ack
   always_comb begin
      next_bus_state = bus_state;
      unique case (bus_state)
         BUS_IDLE: begin
            if (wb_cyc_i && wb_stb_i) begin
               next_bus_state = BUS_ACK;
            end
         end
         BUS_ACK: begin
            next_bus_state = BUS_IDLE;
         end
         default: begin
            next_bus_state = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_state <= BUS_IDLE;
         wb_ack_o <= 1'b0;
      end else begin
         bus_state <= next_bus_state;
         wb_ack_o <= (next_bus_state == BUS_ACK);
      end
   end

   // Read multiplexer; unmapped indices read zero
   always_comb begin
      unique case (index)
         IDX_SOFT_RESET: next_read = capability_word; // RULE5
         IDX_MASTER: next_read = master_vol;
         IDX_HEADPHONE: next_read = headphone_vol;
         IDX_MONO: next_read = mono_vol;
         IDX_SERIAL_CFG: next_read = serial_config_o;
         IDX_STICKY_PAGE: next_read = sticky_page;
         default: next_read = 16'h0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
         wb_dat_o <= {16'h0000, next_read};
      end
   end

   // Master volume: loaded with its muted default by every kind of reset
   always_ff @(posedge clk_i) begin
      if (rst_i || hw_reset || soft_reset) begin // RULE1
         master_vol <= RST_MASTER;
      end else if (write_take && index == IDX_MASTER) begin
         master_vol <= (master_vol & ~lane_mask)
                     | (wb_dat_i[15:0] & lane_mask & MASK_STEREO); // RULE13
      end
   end

   // Headphone volume: own left/right fields
   always_ff @(posedge clk_i) begin
      if (rst_i || hw_reset || soft_reset) begin // RULE1
         headphone_vol <= RST_HEADPHONE;
      end else if (write_take && index == IDX_HEADPHONE) begin
         headphone_vol <= (headphone_vol & ~lane_mask)
                        | (wb_dat_i[15:0] & lane_mask & MASK_STEREO); // RULE10 RULE13
      end
   end

   // Mono volume: muted at 0 dB after reset
   always_ff @(posedge clk_i) begin
      if (rst_i || hw_reset || soft_reset) begin
         mono_vol <= RST_MONO; // RULE11
      end else if (write_take && index == IDX_MONO) begin
         mono_vol <= (mono_vol & ~lane_mask)
                   | (wb_dat_i[15:0] & lane_mask & MASK_MONO); // RULE11 RULE13
      end
   end

   // Serial configuration: soft reset is ignored here
   always_ff @(posedge clk_i) begin
      if (rst_i || hw_reset) begin // RULE2 RULE3
         serial_config_o <= RST_SERIAL_CFG;
      end else if (write_take && index == IDX_SERIAL_CFG) begin
         serial_config_o <= (serial_config_o & ~lane_mask)
                          | (wb_dat_i[15:0] & lane_mask & MASK_SERIAL_CFG);
      end
   end

   // Sticky page word: only power-on reset clears it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin // RULE4
         sticky_page <= RST_STICKY_PAGE;
      end else if (write_take && index == IDX_STICKY_PAGE) begin
         sticky_page <= (sticky_page & ~lane_mask)
                      | (wb_dat_i[15:0] & lane_mask & MASK_STICKY_PAGE);
      end
   end

   // Source fields per channel; fine trims live in the DAC registers
   always_comb begin
      for (int c = 0; c < NUM_MASTER_CHAN; c++) begin
         if (c % 2 == 0) begin
            chan_mute_src[c] = master_vol[LEFT_MUTE_BIT]; // RULE8 RULE12
            chan_code_src[c] = master_vol[LEFT_VOL_LSB +: VOL_WIDTH];
         end else begin
            chan_mute_src[c] = master_vol[RIGHT_MUTE_BIT]; // RULE8
            chan_code_src[c] = master_vol[RIGHT_VOL_LSB +: VOL_WIDTH];
         end
      end
      chan_mute_src[CHAN_HP_LEFT] = headphone_vol[LEFT_MUTE_BIT]; // RULE10
      chan_code_src[CHAN_HP_LEFT] = headphone_vol[LEFT_VOL_LSB +: VOL_WIDTH];
      chan_mute_src[CHAN_HP_RIGHT] = headphone_vol[RIGHT_MUTE_BIT];
      chan_code_src[CHAN_HP_RIGHT] = headphone_vol[RIGHT_VOL_LSB +: VOL_WIDTH];
      chan_mute_src[CHAN_MONO] = mono_vol[LEFT_MUTE_BIT]; // RULE11
      chan_code_src[CHAN_MONO] = mono_vol[RIGHT_VOL_LSB +: VOL_WIDTH];
   end

   // One registered decoder per output channel
   generate
      for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
         cvr_chan_level u_level (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .mute_i(chan_mute_src[g]),
            .code_i(chan_code_src[g]),
            .mute_o(chan_mute_o[g]),
            .atten_o(chan_atten_o[g])
         );
      end
   endgenerate

   // Checks

   sequence s_request;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   sequence s_answer;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   property p_bus_answer;
      @(posedge clk_i) disable iff (rst_i)
      s_request |=> s_answer;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("ack not given for exactly one cycle");

   property p_soft_reset;
      @(posedge clk_i) disable iff (rst_i)
      soft_reset |=> master_vol == RST_MASTER && headphone_vol == RST_HEADPHONE
         && mono_vol == RST_MONO;
   endproperty
   a_soft_reset: assert property (p_soft_reset) // RULE1
      else $error("soft reset did not restore volume defaults");

   property p_serial_keep;
      @(posedge clk_i) disable iff (rst_i)
      soft_reset && !hw_reset |=> $stable(serial_config_o);
   endproperty
   a_serial_keep: assert property (p_serial_keep) // RULE2
      else $error("serial configuration changed on soft reset");

   property p_hw_clear;
      @(posedge clk_i) disable iff (rst_i)
      hw_reset |=> serial_config_o == RST_SERIAL_CFG;
   endproperty
   a_hw_clear: assert property (p_hw_clear) // RULE3
      else $error("hardware reset did not clear serial configuration");

   // A write that lands in the same cycle as a reset is still allowed
   property p_sticky_keep;
      @(posedge clk_i) disable iff (rst_i)
      (hw_reset || soft_reset) && !(write_take && index == IDX_STICKY_PAGE)
         |=> $stable(sticky_page);
   endproperty
   a_sticky_keep: assert property (p_sticky_keep) // RULE4
      else $error("sticky page word changed on a non power-on reset");

   property p_cap_read;
      @(posedge clk_i) disable iff (rst_i)
      s_request ##0 (!wb_we_i && index == IDX_SOFT_RESET)
         |=> wb_dat_o == {16'h0000, 1'b0, 5'h00, CAPABILITY};
   endproperty
   a_cap_read: assert property (p_cap_read) // RULE5 RULE6 RULE7
      else $error("reset register read wrong capability word");

   property p_master_apply;
      @(posedge clk_i) disable iff (rst_i)
      ##1 chan_mute_o[0] == $past(master_vol[15])
         && chan_mute_o[2] == $past(master_vol[15])
         && chan_mute_o[5] == $past(master_vol[7])
         && chan_atten_o[4] == chan_atten_o[2];
   endproperty
   a_master_apply: assert property (p_master_apply) // RULE8
      else $error("master volume not applied to all three outputs");

   property p_att_step;
      @(posedge clk_i) disable iff (rst_i)
      ##1 chan_atten_o[CHAN_HP_RIGHT]
         == ATT_WIDTH'(3 * $past(headphone_vol[4:0]));
   endproperty
   a_att_step: assert property (p_att_step) // RULE9 RULE10
      else $error("headphone attenuation not 1.5 dB per step");

   // Looked at only once reset has let go, so the first edge is not judged
   property p_mono_reset;
      @(posedge clk_i)
      !rst_i && $past(rst_i) |-> mono_vol == RST_MONO && chan_mute_o == '1;
   endproperty
   a_mono_reset: assert property (p_mono_reset) // RULE11
      else $error("mono volume not muted at 0 dB after reset");

   property p_reserved_zero;
      @(posedge clk_i) disable iff (rst_i)
      (master_vol & ~MASK_STEREO) == 16'h0000
         && (headphone_vol & ~MASK_STEREO) == 16'h0000
         && (mono_vol & ~MASK_MONO) == 16'h0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // RULE13
      else $error("reserved volume bit is set");

   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) // RULE1
      else $error("ack held for more than one cycle");

   property p_no_stray_ack;
      @(posedge clk_i) disable iff (rst_i)
      !(wb_cyc_i && wb_stb_i) && !wb_ack_o |=> !wb_ack_o;
   endproperty
   a_no_stray_ack: assert property (p_no_stray_ack) // RULE1
      else $error("ack given without a request");

   property p_hw_volume;
      @(posedge clk_i) disable iff (rst_i)
      hw_reset |=> master_vol == RST_MASTER && headphone_vol == RST_HEADPHONE
         && mono_vol == RST_MONO;
   endproperty
   a_hw_volume: assert property (p_hw_volume) // RULE1
      else $error("hardware reset did not restore volume defaults");

   // Full-word write to the serial word outside a hardware reset
   sequence s_serial_write;
      write_take && index == IDX_SERIAL_CFG && !hw_reset
         && wb_sel_i[1:0] == 2'b11;
   endsequence

   property p_serial_write;
      @(posedge clk_i) disable iff (rst_i)
      s_serial_write
         |=> serial_config_o == ($past(wb_dat_i[15:0]) & MASK_SERIAL_CFG);
   endproperty
   a_serial_write: assert property (p_serial_write) // RULE3
      else $error("serial configuration write did not land");

   property p_reserved_read;
      @(posedge clk_i) disable iff (rst_i)
      s_request ##0 (!wb_we_i && (index == IDX_MASTER
         || index == IDX_HEADPHONE))
         |=> (wb_dat_o[15:0] & ~MASK_STEREO) == 16'h0000
         && wb_dat_o[31:16] == 16'h0000;
   endproperty
   a_reserved_read: assert property (p_reserved_read) // RULE13
      else $error("reserved volume bit read as one");

   property p_mono_apply;
      @(posedge clk_i) disable iff (rst_i)
      ##1 chan_mute_o[CHAN_MONO] == $past(mono_vol[LEFT_MUTE_BIT])
         && chan_atten_o[CHAN_MONO] == ATT_WIDTH'(3 * $past(mono_vol[4:0]));
   endproperty
   a_mono_apply: assert property (p_mono_apply) // RULE11
      else $error("mono level does not follow the mono register");

   property p_hp_left;
      @(posedge clk_i) disable iff (rst_i)
      ##1 chan_mute_o[CHAN_HP_LEFT] == $past(headphone_vol[LEFT_MUTE_BIT])
         && chan_atten_o[CHAN_HP_LEFT]
         == ATT_WIDTH'(3 * $past(headphone_vol[12:8]));
   endproperty
   a_hp_left: assert property (p_hp_left) // RULE10
      else $error("headphone left level does not follow its register");

endmodule

// *** cvr_ctrl_model.sv ***
/*
 Controller-side model: a classic Wishbone master that runs one request each
 time go_i is raised and reports it with a one-cycle done_o.
 Assumes go_i is held until done_o and then dropped at a rising edge.
*/
`timescale 1ns/100ps
module cvr_ctrl_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Request from the bench
   input wire logic go_i,
   input wire logic we_i,
   input wire logic [8:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic done_o,
   output logic [31:0] rdat_o,
   // Wishbone master
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [8:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o,
   input wire logic wb_ack_i,
   input wire logic [31:0] wb_dat_i
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_cyc_o <= 1'b0;
         wb_stb_o <= 1'b0;
         wb_we_o <= 1'b0;
         wb_adr_o <= 9'h000;
         wb_sel_o <= 4'h0;
         wb_dat_o <= 32'h0;
         done_o <= 1'b0;
         rdat_o <= 32'h0;
      end else begin
         done_o <= 1'b0;
         if (wb_cyc_o && wb_ack_i) begin
            // Released address and data lines show the inverse; we and sel keep their last value
            wb_cyc_o <= 1'b0;
            wb_stb_o <= 1'b0;
            wb_adr_o <= ~wb_adr_o;
            wb_dat_o <= ~wb_dat_o;
            rdat_o <= wb_dat_i;
            done_o <= 1'b1;
         end else if (!wb_cyc_o && go_i && !done_o) begin
            wb_cyc_o <= 1'b1;
            wb_stb_o <= 1'b1;
            wb_we_o <= we_i;
            wb_adr_o <= adr_i;
            wb_sel_o <= 4'h3;
            wb_dat_o <= dat_i;
         end
      end
   end
endmodule

// *** codec_reset_and_output_volume_regs_test.sv ***
/*
 Self-checking bench for the register bank, driven through the controller
 model. Assumes the design's default capability parameter.
*/
`timescale 1ns/100ps
module codec_reset_and_output_volume_regs_test;
   import cvr_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic hw_reset_n_i = 1'b1;
   logic go = 1'b0;
   logic we = 1'b0;
   logic [8:0] adr = 9'h000;
   logic [31:0] wdat = 32'h0;
   logic done, wb_cyc, wb_stb, wb_we, wb_ack;
   logic [31:0] rdat, wb_dat_w, wb_dat_r;
   logic [8:0] wb_adr;
   logic [3:0] wb_sel;
   logic [15:0] serial_config;
   logic [NUM_CHAN-1:0] chan_mute;
   logic [NUM_CHAN-1:0][ATT_WIDTH-1:0] chan_atten;
   int n_fail = 0;
   int n_tests = 0;
   int cycles = 0;

   cvr_regs i_cvr_regs (.clk_i(clk_i), .rst_i(rst_i),
      .hw_reset_n_i(hw_reset_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
      .serial_config_o(serial_config), .chan_mute_o(chan_mute),
      .chan_atten_o(chan_atten));
   cvr_ctrl_model i_cvr_ctrl_model (.clk_i(clk_i), .rst_i(rst_i),
      .go_i(go), .we_i(we), .adr_i(adr), .dat_i(wdat), .done_o(done),
      .rdat_o(rdat), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
      .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_dat_w),
      .wb_ack_i(wb_ack), .wb_dat_i(wb_dat_r));

   initial forever #5 clk_i = ~clk_i;

   task end_sim;
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Cut a hang short
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         end_sim();
      end
   end

   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Entered and left at a rising edge
   task bus(input logic w, input logic [8:0] a, input logic [31:0] d);
      we <= w;
      adr <= a;
      wdat <= d;
      go <= 1'b1;
      do @(negedge clk_i); while (done !== 1'b1);
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
   endtask

   task rd(input logic [8:0] a, input logic [15:0] exp, input string name);
      bus(1'b0, a, 32'h0);
      chk(name, rdat, {16'h0, exp});
   endtask

   task wr(input logic [8:0] a, input logic [15:0] d);
      bus(1'b1, a, {16'h0, d});
   endtask

   task lvl(input int ch, input logic m, input logic [6:0] att);
      chk("chan_mute", chan_mute[ch], m);
      chk("chan_atten", chan_atten[ch], att);
   endtask

   task t_reset;
      rd(9'h000, {1'b0, 5'h00, 10'h010}, "capability");
      rd(9'h008, 16'h8080, "master");
      rd(9'h010, 16'h8080, "headphone");
      rd(9'h018, 16'h8000, "mono");
      chk("mute_all", chan_mute, 9'h1ff);
   endtask

   task t_master;
      wr(9'h008, 16'hffff);
      rd(9'h008, 16'h9f9f, "master_mask");
      wr(9'h008, 16'h0a05);
      for (int c = 0; c < 6; c += 2) begin
         lvl(c, 1'b0, 7'h1e);
         lvl(c + 1, 1'b0, 7'h0f);
      end
      lvl(CHAN_HP_LEFT, 1'b1, 7'h00);
      wr(9'h008, 16'h9f1f);
      lvl(0, 1'b1, 7'h5d);
      lvl(5, 1'b0, 7'h5d);
   endtask

   task t_hp_mono;
      wr(9'h010, 16'h0083);
      lvl(CHAN_HP_LEFT, 1'b0, 7'h00);
      lvl(CHAN_HP_RIGHT, 1'b1, 7'h09);
      lvl(1, 1'b0, 7'h5d);
      wr(9'h018, 16'hffff);
      rd(9'h018, 16'h801f, "mono_mask");
      lvl(CHAN_MONO, 1'b1, 7'h5d);
      wr(9'h018, 16'h0001);
      lvl(CHAN_MONO, 1'b0, 7'h03);
   endtask

   task t_soft;
      wr(9'h1d0, 16'hffff);
      wr(9'h1f0, 16'h1234);
      wr(9'h000, 16'h0000);
      rd(9'h000, 16'h0010, "capability_ro");
      rd(9'h008, 16'h8080, "master_soft");
      rd(9'h010, 16'h8080, "hp_soft");
      rd(9'h018, 16'h8000, "mono_soft");
      rd(9'h1d0, 16'hff80, "serial_soft");
      chk("serial_out", serial_config, 16'hff80);
      rd(9'h1f0, 16'h1234, "sticky_soft");
      lvl(0, 1'b1, 7'h00);
   endtask

   task t_hw;
      wr(9'h008, 16'h0000);
      hw_reset_n_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      hw_reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(9'h1d0, 16'h0000, "serial_hw");
      chk("serial_out_hw", serial_config, 16'h0000);
      rd(9'h1f0, 16'h1234, "sticky_hw");
      rd(9'h008, 16'h8080, "master_hw");
      rd(9'h020, 16'h0000, "unmapped");
      rd(9'h060, 16'h0000, "dac_trim_elsewhere");
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(9'h1f0, 16'h0000, "sticky_por");
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_master();
      t_hp_mono();
      t_soft();
      t_hw();
      end_sim();
   end
endmodule
